// ===== logic/fsoc_pkg.sv
package fsoc_pkg;

  // register map and bit layout of the sync output settings
  localparam int unsigned FSOC_ADDR_W = 7;
  localparam int unsigned FSOC_DATA_W = 8;
  localparam logic [FSOC_ADDR_W-1:0] FSOC_SYNC_OUTPUT_CONFIG_ADDR = 7'h7A;
  localparam logic [FSOC_DATA_W-1:0] FSOC_SYNC_OUTPUT_CONFIG_RESET = 8'h00;
  localparam logic [FSOC_DATA_W-1:0] FSOC_SYNC_OUTPUT_CONFIG_MASK = 8'h8F;
  localparam logic [FSOC_DATA_W-1:0] FSOC_READ_IDLE = 8'h00;
  localparam int unsigned FSOC_SOURCE_SELECT_BIT = 7;
  localparam int unsigned FSOC_FRAME_POLARITY_BIT = 3;
  localparam int unsigned FSOC_FRAME_PULSE_BIT = 2;
  localparam int unsigned FSOC_MULTIFRAME_POLARITY_BIT = 1;
  localparam int unsigned FSOC_MULTIFRAME_PULSE_BIT = 0;

  // channel numbering for the two sync outputs
  localparam int unsigned FSOC_CHANNELS = 2;
  localparam int unsigned FSOC_CH_FRAME = 0;
  localparam int unsigned FSOC_CH_MULTIFRAME = 1;

  // what one phase loop hands to this block, all in the system clock domain
  typedef struct packed {
    logic frame_level;      // 8 kHz square reference, high in first half
    logic multiframe_level; // 2 kHz square reference, high in first half
    logic o2_tick;          // one-cycle pulse per second clock output period
  } fsoc_loop_sync_t;

  // per-output settings as decoded from the register
  typedef struct packed {
    logic polarity;
    logic pulse_mode;
  } fsoc_shape_t;

  // register access from the serial port decoder
  typedef struct packed {
    logic write;
    logic read;
    logic [FSOC_ADDR_W-1:0] addr;
    logic [FSOC_DATA_W-1:0] wdata;
  } fsoc_cfg_req_t;

endpackage : fsoc_pkg

// ===== logic/fsoc_shaper.sv
`timescale 1ns/1ps
module fsoc_shaper (
  clk,
  rst,
  ref_level,
  o2_tick,
  o2_enable,
  shape,
  sync_out
);
  import fsoc_pkg::*;
  input wire logic clk;
  input wire logic rst;
  input wire logic ref_level;
  input wire logic o2_tick;
  input wire logic o2_enable;
  input wire fsoc_pkg::fsoc_shape_t shape;
  output logic sync_out;

  logic ref_d;
  logic rise;
  logic pol_q;
  logic mode_q;
  logic pulse_q;
  logic next_pol;
  logic next_mode;
  logic next_pulse;
  logic next_raw;

  assign rise = ref_level & ~ref_d;

  ////////////////////////////////////////////////////////////////////////////
  // settings only move at the period start, so a change mid-period never
  // cuts a high or low phase short
  always_comb begin
    next_pol = rise ? shape.polarity : pol_q;
    // pulsed shape needs the second clock output running; without it a
    // pulse would never end, so fall back to the square wave
    next_mode = rise ? (shape.pulse_mode & o2_enable) : mode_q;
    next_pulse = rise ? 1'b1 : (o2_tick ? 1'b0 : pulse_q);
    next_raw = next_mode ? next_pulse : ref_level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // assume high so a reference already high at release is not a false period start
      ref_d <= 1'b1;
    end else begin
      ref_d <= ref_level;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pol_q <= 1'b0;
      mode_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      pol_q <= next_pol;
      mode_q <= next_mode;
      pulse_q <= next_pulse;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= next_raw ^ next_pol;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence period_start_s;
    ref_level && !ref_d;
  endsequence

  period_edge_a: assert property (@(posedge clk) disable iff (rst)
    period_start_s |=> sync_out == !$past(shape.polarity))
    else $error("sync output wrong level at period start");

  pulse_end_a: assert property (@(posedge clk) disable iff (rst)
    (mode_q && o2_tick && !period_start_s) |=> sync_out == pol_q)
    else $error("pulse did not end on second clock period");

  square_follow_a: assert property (@(posedge clk) disable iff (rst)
    (!mode_q && !period_start_s) |=> sync_out == ($past(ref_level) ^ pol_q))
    else $error("square wave does not follow reference");

  no_runt_a: assert property (@(posedge clk) disable iff (rst)
    !period_start_s |=> $stable(pol_q) && $stable(mode_q))
    else $error("shape setting changed inside a period");

endmodule : fsoc_shaper

// ===== logic/fsoc_sync_output_control.sv
`timescale 1ns/1ps
module fsoc_sync_output_control #(
  parameter int unsigned ADDR_W = 7,
  parameter int unsigned DATA_W = 8
) (
  clk,
  rst,
  cfg_req,
  cfg_rdata,
  cfg_rvalid,
  primary_phase_loop,
  secondary_phase_loop,
  second_clock_output_enable,
  sync_source_select,
  frame_sync_output,
  multiframe_sync_output
);
  import fsoc_pkg::*;
  input wire logic clk;
  input wire logic rst;
  input wire fsoc_pkg::fsoc_cfg_req_t cfg_req;
  output logic [DATA_W-1:0] cfg_rdata;
  output logic cfg_rvalid;
  input wire fsoc_pkg::fsoc_loop_sync_t primary_phase_loop;
  input wire fsoc_pkg::fsoc_loop_sync_t secondary_phase_loop;
  input wire logic second_clock_output_enable;
  output logic sync_source_select;
  output logic frame_sync_output;
  output logic multiframe_sync_output;

  ////////////////////////////////////////////////////////////////////////////
  // the register layout is fixed by the package; other widths cannot serve
  if (ADDR_W != FSOC_ADDR_W || DATA_W != FSOC_DATA_W) begin : g_bad_width
    $error("fsoc_sync_output_control: address or data width unsupported");
  end

  function automatic logic hits_config(input logic [FSOC_ADDR_W-1:0] addr);
    hits_config = (addr == FSOC_SYNC_OUTPUT_CONFIG_ADDR);
  endfunction : hits_config

  function automatic fsoc_shape_t shape_of(input logic [FSOC_DATA_W-1:0] cfg,
                                           input int unsigned ch);
    fsoc_shape_t s;
    if (ch == FSOC_CH_FRAME) begin
      s.polarity = cfg[FSOC_FRAME_POLARITY_BIT];
      s.pulse_mode = cfg[FSOC_FRAME_PULSE_BIT];
    end else begin
      s.polarity = cfg[FSOC_MULTIFRAME_POLARITY_BIT];
      s.pulse_mode = cfg[FSOC_MULTIFRAME_PULSE_BIT];
    end
    shape_of = s;
  endfunction : shape_of

  logic [FSOC_DATA_W-1:0] sync_output_config;
  fsoc_loop_sync_t selected_loop;
  logic [FSOC_CHANNELS-1:0] ref_levels;
  logic [FSOC_CHANNELS-1:0] shaped;

  ////////////////////////////////////////////////////////////////////////////
  // register write; unused bits are never stored so they read back as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_output_config <= FSOC_SYNC_OUTPUT_CONFIG_RESET;
    end else if (cfg_req.write && hits_config(cfg_req.addr)) begin
      sync_output_config <= cfg_req.wdata & FSOC_SYNC_OUTPUT_CONFIG_MASK;
    end
  end

  // read answers one cycle after the request; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata <= FSOC_READ_IDLE;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.read;
      if (cfg_req.read && hits_config(cfg_req.addr)) begin
        cfg_rdata <= sync_output_config;
      end else begin
        cfg_rdata <= FSOC_READ_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection; the switch takes effect at once and is not glitch-safe: in square mode the
  // shapers pass the new reference straight through, and only settings wait for a rising edge
  always_comb begin
    if (sync_output_config[FSOC_SOURCE_SELECT_BIT]) begin
      selected_loop = secondary_phase_loop;
    end else begin
      selected_loop = primary_phase_loop;
    end
    ref_levels[FSOC_CH_FRAME] = selected_loop.frame_level;
    ref_levels[FSOC_CH_MULTIFRAME] = selected_loop.multiframe_level;
  end

  // the clock output muxes downstream read this to follow the same loop
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_source_select <= 1'b0;
    end else begin
      sync_source_select <= sync_output_config[FSOC_SOURCE_SELECT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one shaper per sync output, both paced by the second clock output
  for (genvar ch = 0; ch < FSOC_CHANNELS; ch++) begin : g_shaper
    fsoc_shaper u_shaper (
      .clk(clk),
      .rst(rst),
      .ref_level(ref_levels[ch]),
      .o2_tick(selected_loop.o2_tick),
      .o2_enable(second_clock_output_enable),
      .shape(shape_of(sync_output_config, ch)),
      .sync_out(shaped[ch])
    );
  end

  // shaper outputs are already flops; the wires below only rename them
  assign frame_sync_output = shaped[FSOC_CH_FRAME];
  assign multiframe_sync_output = shaped[FSOC_CH_MULTIFRAME];

  ////////////////////////////////////////////////////////////////////////////
  sequence config_write_s;
    cfg_req.write && hits_config(cfg_req.addr);
  endsequence

  sequence config_read_s;
    cfg_req.read && hits_config(cfg_req.addr);
  endsequence

  reset_zero_a: assert property (@(posedge clk)
    $past(rst) |-> sync_output_config == FSOC_SYNC_OUTPUT_CONFIG_RESET)
    else $error("config register not zero after reset");

  unused_zero_a: assert property (@(posedge clk) disable iff (rst)
    config_write_s ##1 config_read_s |=> (cfg_rdata & ~FSOC_SYNC_OUTPUT_CONFIG_MASK) == FSOC_READ_IDLE
      && cfg_rvalid)
    else $error("unused config bits read nonzero");

  write_readback_a: assert property (@(posedge clk) disable iff (rst)
    config_write_s ##1 config_read_s |=> cfg_rdata == ($past(cfg_req.wdata, 2) & FSOC_SYNC_OUTPUT_CONFIG_MASK))
    else $error("config write not read back");

  source_follow_a: assert property (@(posedge clk) disable iff (rst)
    config_write_s |=> ##1 sync_source_select == $past(cfg_req.wdata[FSOC_SOURCE_SELECT_BIT], 2))
    else $error("source select did not follow register");

endmodule : fsoc_sync_output_control

// ===== testbench/fsoc_loop_model.sv
`timescale 1ns/1ps
module fsoc_loop_model #(
  parameter int unsigned FRAME_CYCLES = 16,
  parameter int unsigned MULTIFRAME_CYCLES = 64,
  parameter int unsigned O2_CYCLES = 4,
  parameter int unsigned START = 0
) (
  clk,
  loop_out
);
  import fsoc_pkg::*;
  input wire logic clk;
  output fsoc_pkg::fsoc_loop_sync_t loop_out;
  int unsigned count;
  // free running: a phase loop never pauses its references
  initial count = START;
  always @(posedge clk) begin
    count <= (count + 1) % MULTIFRAME_CYCLES;
  end
  assign loop_out = '{frame_level: (count % FRAME_CYCLES) < (FRAME_CYCLES / 2),
    multiframe_level: count < (MULTIFRAME_CYCLES / 2),
    o2_tick: (count % O2_CYCLES) == 0};
endmodule : fsoc_loop_model

// ===== testbench/fsoc_sync_output_control_test.sv
`timescale 1ns/1ps
module fsoc_sync_output_control_test;
  import fsoc_pkg::*;
  logic clk;
  logic rst;
  fsoc_cfg_req_t cfg_req;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  fsoc_loop_sync_t primary_phase_loop;
  fsoc_loop_sync_t secondary_phase_loop;
  logic second_clock_output_enable;
  logic sync_source_select;
  logic frame_sync_output;
  logic multiframe_sync_output;
  int num_errors;
  int checks_done;
  int cyc;
  logic [7:0] rd;
  // {config, o2 enable, frame at +2 +5 +10, multiframe at +2 +5 +34}
  logic [14:0] rows [9];
  fsoc_sync_output_control dut (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .primary_phase_loop(primary_phase_loop),
    .secondary_phase_loop(secondary_phase_loop), .second_clock_output_enable(second_clock_output_enable),
    .sync_source_select(sync_source_select), .frame_sync_output(frame_sync_output),
    .multiframe_sync_output(multiframe_sync_output));
  fsoc_loop_model #(.START(0)) u_primary (.clk(clk), .loop_out(primary_phase_loop));
  // offset so a wrong source choice shows up as shifted edges
  fsoc_loop_model #(.START(5)) u_secondary (.clk(clk), .loop_out(secondary_phase_loop));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic check_bit(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t exp=%0h got=%0h", $time, exp, got);
    end
  endtask : check_bit
  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t exp=%0h got=%0h", $time, exp, got);
    end
  endtask : check_byte
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    cfg_req.write <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    cfg_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    cfg_req.read <= 1'b0;
    #1;
    check_bit(1'b1, cfg_rvalid);
    d = cfg_rdata;
  endtask : reg_read
  // waits for a multiframe start of the chosen loop; cycle count restarts there
  task automatic wait_edge(input logic sec);
    logic prev;
    logic lvl;
    prev = 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      lvl = sec ? secondary_phase_loop.multiframe_level : primary_phase_loop.multiframe_level;
      if (lvl && !prev) begin
        cyc = 0;
        return;
      end
      prev = lvl;
    end
    check_bit(1'b1, 1'b0);
    stop_test();
  endtask : wait_edge
  task automatic step(input int k);
    repeat (k - cyc) @(posedge clk);
    #1;
    cyc = k;
  endtask : step
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    rows = '{{8'h00, 1'b1, 3'b110, 3'b110}, {8'h08, 1'b1, 3'b001, 3'b110}, {8'h04, 1'b1, 3'b100, 3'b110},
      {8'h0C, 1'b1, 3'b011, 3'b110}, {8'h02, 1'b1, 3'b110, 3'b001}, {8'h01, 1'b1, 3'b110, 3'b100},
      {8'h03, 1'b1, 3'b110, 3'b011}, {8'h85, 1'b1, 3'b100, 3'b100}, {8'h8F, 1'b0, 3'b001, 3'b001}};
    num_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    cfg_req = '0;
    second_clock_output_enable = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check_bit(1'b0, frame_sync_output);
    reg_read(FSOC_SYNC_OUTPUT_CONFIG_ADDR, rd);
    check_byte(8'h00, rd);
    for (int i = 0; i < 9; i++) begin
      reg_write(FSOC_SYNC_OUTPUT_CONFIG_ADDR, rows[i][14:7]);
      second_clock_output_enable <= rows[i][6];
      wait_edge(rows[i][14]);
      wait_edge(rows[i][14]);
      step(2);
      check_bit(rows[i][5], frame_sync_output);
      check_bit(rows[i][2], multiframe_sync_output);
      step(5);
      check_bit(rows[i][4], frame_sync_output);
      check_bit(rows[i][1], multiframe_sync_output);
      step(10);
      check_bit(rows[i][3], frame_sync_output);
      step(34);
      check_bit(rows[i][0], multiframe_sync_output);
      check_bit(rows[i][14], sync_source_select);
      $display("row %0d done", i);
    end
    reg_write(FSOC_SYNC_OUTPUT_CONFIG_ADDR, 8'hFF);
    reg_read(FSOC_SYNC_OUTPUT_CONFIG_ADDR, rd);
    check_byte(8'h8F, rd);
    reg_write(7'h7B, 8'h00);
    reg_read(7'h7B, rd);
    check_byte(8'h00, rd);
    reg_read(FSOC_SYNC_OUTPUT_CONFIG_ADDR, rd);
    check_byte(8'h8F, rd);
    // back-to-back write then read must return the new value
    @(posedge clk);
    cfg_req <= '{write: 1'b1, read: 1'b0, addr: FSOC_SYNC_OUTPUT_CONFIG_ADDR, wdata: 8'h81};
    @(posedge clk);
    cfg_req <= '{write: 1'b0, read: 1'b1, addr: FSOC_SYNC_OUTPUT_CONFIG_ADDR, wdata: 8'h00};
    @(posedge clk);
    cfg_req.read <= 1'b0;
    #1;
    check_bit(1'b1, cfg_rvalid);
    check_byte(8'h81, cfg_rdata);
    $display("register test done");
    // polarity change written mid-period must wait for the next frame start
    reg_write(FSOC_SYNC_OUTPUT_CONFIG_ADDR, 8'h00);
    second_clock_output_enable <= 1'b1;
    wait_edge(1'b0);
    wait_edge(1'b0);
    step(2);
    reg_write(FSOC_SYNC_OUTPUT_CONFIG_ADDR, 8'h08);
    cyc = 4;
    step(5);
    check_bit(1'b1, frame_sync_output);
    step(10);
    check_bit(1'b0, frame_sync_output);
    step(18);
    check_bit(1'b0, frame_sync_output);
    step(26);
    check_bit(1'b1, frame_sync_output);
    $display("mid-period change test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check_bit(1'b0, sync_source_select);
    check_bit(1'b0, multiframe_sync_output);
    reg_read(FSOC_SYNC_OUTPUT_CONFIG_ADDR, rd);
    check_byte(8'h00, rd);
    $display("second reset test done");
    stop_test();
  end
endmodule : fsoc_sync_output_control_test
